/* resov_pkg.sv */
package resov_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_PERIOD_NS = 1_000_000;
  localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
  localparam longint FORCE_TIMEOUT_MIN = 5;
  localparam longint FORCE_TIMEOUT_CYCLES =
    FORCE_TIMEOUT_MIN * 64'd60 * 64'd1_000_000_000 / CLK_PERIOD_NS;
  // ==========================================================
  // widths and counts
  localparam int SAMPLE_W = 16;
  localparam int LEVEL_W = 16;
  localparam int SCALE_W = 16;
  localparam int DELAY_W = 20;
  localparam int CNT_W = 16;
  localparam int PCT_W = 7;
  localparam int DATE_W = 32;
  localparam int TOD_W = 34;
  localparam int NUM_STAGES = 2;
  localparam int NUM_GROUPS = 4;
  localparam int NUM_RECORDS = 8;
  localparam int DFT_POINTS = 8;
  localparam int SCALE_SHIFT = 16;
  localparam int FORCE_CNT_W = 36;
  // ==========================================================
  // values
  localparam logic [PCT_W-1:0] PCT_TRIP = 7'h64;
  localparam logic [PCT_W-1:0] PCT_BELOW_TRIP = 7'h63;
  localparam logic [7:0] PCT_STEP = 8'h64;
  localparam logic [LEVEL_W-1:0] PICKUP_RESET = 16'hFFFF;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 20'h001F4;
  localparam logic [1:0] GROUP_RESET = 2'h0;
  localparam logic [1:0] GROUP_BY_SIGNAL = 2'h1;
  localparam logic MODE_PHASE = 1'b0;
  localparam logic MODE_LINE_RESIDUAL = 1'b1;
  localparam int STAGE_LOW = 0;
  localparam int STAGE_HIGH = 1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BLOCKED = 2'b01,
    ST_START = 2'b10,
    ST_TRIP = 2'b11
  } stage_status_e;

  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_PHYSICAL = 3'b001,
    SRC_SOFT_INPUT = 3'b010,
    SRC_INDICATOR = 3'b011,
    SRC_SOFT_OUTPUT = 3'b100
  } group_source_e;
endpackage

/* residual_stage_timer.sv */
`timescale 1ns/1ps
module residual_stage_timer (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // measurement and settings
  input wire logic [resov_pkg::LEVEL_W-1:0] level_in,
  input wire logic [resov_pkg::LEVEL_W-1:0] pickup_in,
  input wire logic [resov_pkg::DELAY_W-1:0] delay_ms_in,
  input wire logic block_in,
  input wire logic ms_tick_in,
  // stage outputs
  output logic start_out,
  output logic trip_out,
  // fault summary, one pulse per fault
  output logic rec_valid_out,
  output logic [resov_pkg::PCT_W-1:0] rec_pct_out,
  output logic [resov_pkg::LEVEL_W-1:0] rec_peak_out
);
  typedef struct packed {
    logic start;
    logic trip;
    logic [resov_pkg::DELAY_W-1:0] elapsed;
    logic [27:0] acc;
    logic [resov_pkg::PCT_W-1:0] pct;
    logic [resov_pkg::LEVEL_W-1:0] peak;
    logic rec_valid;
    logic [resov_pkg::PCT_W-1:0] rec_pct;
    logic [resov_pkg::LEVEL_W-1:0] rec_peak;
  } timer_state_s;

  timer_state_s state_reg;
  timer_state_s state_next;
  logic over;

  // ==========================================================
  // definite-time pick-up and delay
  always_comb begin
    state_next = state_reg;
    state_next.rec_valid = 1'b0;
    over = !block_in && (level_in > pickup_in);
    if (!over) begin
      // a drop-out before trip still leaves a record of the episode
      if (state_reg.start && !state_reg.trip) begin
        state_next.rec_valid = 1'b1;
        state_next.rec_pct = state_reg.pct;
        state_next.rec_peak = state_reg.peak;
      end
      state_next.start = 1'b0;
      state_next.trip = 1'b0;
      state_next.elapsed = '0;
      state_next.acc = '0;
      state_next.pct = '0;
      state_next.peak = '0;
    end else begin
      state_next.start = 1'b1;
      if (level_in > state_reg.peak) begin
        state_next.peak = level_in;
      end
      if (!state_reg.trip) begin
        if (ms_tick_in && state_reg.elapsed != '1) begin
          state_next.elapsed = state_reg.elapsed + 1'b1;
        end
        // percent tracks elapsed*100/delay without a divider; it may
        // lag by up to 100 cycles, which is far below one millisecond
        if (ms_tick_in) begin
          state_next.acc = state_reg.acc + 28'(resov_pkg::PCT_STEP);
        end else if (delay_ms_in != '0 && state_reg.acc >= 28'(delay_ms_in)
                     && state_reg.pct < resov_pkg::PCT_BELOW_TRIP) begin
          state_next.acc = state_reg.acc - 28'(delay_ms_in);
          state_next.pct = state_reg.pct + 1'b1;
        end
        if (state_reg.start && state_reg.elapsed >= delay_ms_in) begin
          state_next.trip = 1'b1;
          state_next.pct = resov_pkg::PCT_TRIP;
          state_next.rec_valid = 1'b1;
          state_next.rec_pct = resov_pkg::PCT_TRIP;
          state_next.rec_peak = state_next.peak;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign start_out = state_reg.start;
  assign trip_out = state_reg.trip;
  assign rec_valid_out = state_reg.rec_valid;
  assign rec_pct_out = state_reg.rec_pct;
  assign rec_peak_out = state_reg.rec_peak;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_over;
    !block_in && (level_in > pickup_in);
  endsequence
  sequence s_trip_edge;
    $rose(trip_out);
  endsequence

  a_start_follows_level: assert property (s_over |=> start_out)
    else $error("start missing after level above pick-up");
  a_trip_needs_start: assert property (trip_out |-> start_out)
    else $error("trip without start");
  a_trip_after_delay: assert property (
    s_trip_edge |-> $past(state_reg.elapsed) >= $past(delay_ms_in))
    else $error("trip before delay elapsed");
  a_trip_full_pct: assert property (
    s_trip_edge |-> rec_valid_out && rec_pct_out == 7'h64)
    else $error("trip record not at full percent");
  a_drop_resets: assert property (
    start_out && !(!block_in && (level_in > pickup_in))
    |=> !start_out && state_reg.elapsed == '0)
    else $error("drop-out did not reset timing");
endmodule

/* residual_overvoltage_stage.sv */
`timescale 1ns/1ps
// Summary of operation
// - low-set and high-set stages, independent settings
// - level above pick-up raises start
// - over-level longer than delay raises trip
// - definite time delay, magnitude independent
// - four setting groups, one active
// - group source: none, input, soft, indicator, output
// - status idle/blocked/start/trip; forcing needs flag
// - start and trip counters, clearable
// - force flag clears after five minutes
// - one force flag shared by everything
// - setting changes need password authorization
// - keep eight latest fault records
// - elapsed delay in percent, trip is 100
// - record time stamp with date and milliseconds
// - phase mode sums the three phase voltages
// - line-plus-residual mode uses measured residual
// - fundamental plus 7th/9th aliases, third harmonic rejected
// - levels in percent of nominal over root three
module residual_overvoltage_stage #(
  parameter logic [15:0] MS_CYCLES = 16'(resov_pkg::MS_CYCLES),
  parameter logic [resov_pkg::FORCE_CNT_W-1:0] FORCE_TIMEOUT_CYCLES =
    36'(resov_pkg::FORCE_TIMEOUT_CYCLES)
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // voltage samples, eight per fundamental cycle
  input wire logic sample_strobe_in,
  input wire logic signed [resov_pkg::SAMPLE_W-1:0] phase_a_in,
  input wire logic signed [resov_pkg::SAMPLE_W-1:0] phase_b_in,
  input wire logic signed [resov_pkg::SAMPLE_W-1:0] phase_c_in,
  input wire logic signed [resov_pkg::SAMPLE_W-1:0] residual_in,
  input wire logic measurement_mode_in,
  input wire logic [resov_pkg::SCALE_W-1:0] phase_scale_in,
  input wire logic [resov_pkg::SCALE_W-1:0] residual_scale_in,
  // settings access
  input wire logic password_ok_in,
  input wire logic cfg_write_in,
  input wire logic [1:0] cfg_group_in,
  input wire logic cfg_stage_in,
  input wire logic [resov_pkg::LEVEL_W-1:0] cfg_pickup_in,
  input wire logic [resov_pkg::DELAY_W-1:0] cfg_delay_in,
  input wire logic group_write_in,
  input wire logic [1:0] group_manual_in,
  input wire logic source_write_in,
  input wire logic [2:0] group_select_source_in,
  // group select signals
  input wire logic physical_input_n_in,
  input wire logic soft_input_n_in,
  input wire logic indicator_signal_n_in,
  input wire logic soft_output_n_in,
  // blocking and forcing
  input wire logic [1:0] block_in,
  input wire logic force_set_in,
  input wire logic force_clear_in,
  input wire logic force_write_in,
  input wire logic force_stage_in,
  input wire logic [1:0] force_status_in,
  // counter clears
  input wire logic [1:0] start_count_clear_in,
  input wire logic [1:0] trip_count_clear_in,
  // real-time clock
  input wire logic [resov_pkg::DATE_W-1:0] rtc_date_in,
  input wire logic [resov_pkg::TOD_W-1:0] rtc_time_in,
  // fault record read
  input wire logic [2:0] rec_index_in,
  // stage outputs
  output logic [1:0] start_out,
  output logic [1:0] trip_out,
  output logic [1:0][1:0] status_out,
  output logic [1:0][resov_pkg::CNT_W-1:0] start_event_count_out,
  output logic [1:0][resov_pkg::CNT_W-1:0] trip_event_count_out,
  output logic [1:0] active_settings_group_out,
  output logic force_flag_out,
  output logic [resov_pkg::LEVEL_W-1:0] supervised_residual_level_out,
  // fault record
  output logic [3:0] rec_count_out,
  output logic [resov_pkg::DATE_W-1:0] rec_date_out,
  output logic [resov_pkg::TOD_W-1:0] rec_time_out,
  output logic [resov_pkg::LEVEL_W-1:0] rec_level_out,
  output logic [resov_pkg::PCT_W-1:0] elapsed_delay_percent_out,
  output logic [1:0] rec_group_out,
  output logic rec_stage_out
);
  localparam int LW = resov_pkg::LEVEL_W;
  localparam int NR = resov_pkg::NUM_RECORDS;

  typedef struct packed {
    logic [2:0] pin_sync;
    logic phys_level;
    logic signed [31:0] acc_re;
    logic signed [31:0] acc_im;
    logic [2:0] dft_idx;
    logic [LW-1:0] level;
    logic [3:0][1:0][LW-1:0] pickup;
    logic [3:0][1:0][resov_pkg::DELAY_W-1:0] delay_ms;
    logic [1:0] manual_group;
    resov_pkg::group_source_e source;
    logic [1:0] active_grp;
    logic force_flag;
    logic [resov_pkg::FORCE_CNT_W-1:0] force_cnt;
    logic [15:0] ms_cnt;
    logic ms_tick;
    logic [1:0] ovr_en;
    logic [1:0][1:0] ovr_val;
    logic [1:0] prev_start;
    logic [1:0] prev_trip;
    logic [1:0][resov_pkg::CNT_W-1:0] start_cnt;
    logic [1:0][resov_pkg::CNT_W-1:0] trip_cnt;
    logic [1:0] start;
    logic [1:0] trip;
    logic [1:0][1:0] status;
    logic [NR-1:0][resov_pkg::DATE_W-1:0] r_date;
    logic [NR-1:0][resov_pkg::TOD_W-1:0] r_time;
    logic [NR-1:0][LW-1:0] r_level;
    logic [NR-1:0][resov_pkg::PCT_W-1:0] r_pct;
    logic [NR-1:0][1:0] r_group;
    logic [NR-1:0] r_stage;
    logic [2:0] wr_ptr;
    logic [3:0] rec_count;
    logic [resov_pkg::DATE_W-1:0] o_date;
    logic [resov_pkg::TOD_W-1:0] o_time;
    logic [LW-1:0] o_level;
    logic [resov_pkg::PCT_W-1:0] o_pct;
    logic [1:0] o_group;
    logic o_stage;
  } top_state_s;

  top_state_s state_reg;
  top_state_s state_next;
  logic [1:0] st_start;
  logic [1:0] st_trip;
  logic [1:0] st_rec_valid;
  logic [1:0][resov_pkg::PCT_W-1:0] st_rec_pct;
  logic [1:0][LW-1:0] st_rec_peak;

  // one-cycle sine/cosine table, scaled by 256
  function automatic logic signed [9:0] dft_coef(input logic [2:0] k);
    case (k)
      3'h0: return 10'sh100;
      3'h1, 3'h7: return 10'sh0B5;
      3'h2, 3'h6: return 10'sh000;
      3'h3, 3'h5: return -10'sh0B5;
      default: return -10'sh100;
    endcase
  endfunction

  function automatic logic [31:0] abs32(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction

  // ==========================================================
  // stages
  for (genvar s = 0; s < resov_pkg::NUM_STAGES; s++) begin : g_stage
    residual_stage_timer u_timer (
      .sys_clk_in(sys_clk_in),
      .resetn_in(resetn_in),
      .level_in(state_reg.level),
      .pickup_in(state_reg.pickup[state_reg.active_grp][s]),
      .delay_ms_in(state_reg.delay_ms[state_reg.active_grp][s]),
      .block_in(block_in[s]),
      .ms_tick_in(state_reg.ms_tick),
      .start_out(st_start[s]),
      .trip_out(st_trip[s]),
      .rec_valid_out(st_rec_valid[s]),
      .rec_pct_out(st_rec_pct[s]),
      .rec_peak_out(st_rec_peak[s])
    );
  end

  // ==========================================================
  // next state
  always_comb begin
    logic signed [17:0] x;
    logic signed [27:0] p_re;
    logic signed [27:0] p_im;
    logic signed [31:0] f_re;
    logic signed [31:0] f_im;
    logic [31:0] mx;
    logic [31:0] mn;
    logic [31:0] mag;
    logic [47:0] scaled;
    logic sel_level;
    logic [2:0] wp;
    x = '0;
    p_re = '0;
    p_im = '0;
    f_re = '0;
    f_im = '0;
    mx = '0;
    mn = '0;
    mag = '0;
    scaled = '0;
    sel_level = 1'b0;
    wp = state_reg.wr_ptr;
    state_next = state_reg;

    // only the second and third flops are compared
    state_next.pin_sync = {state_reg.pin_sync[1:0], physical_input_n_in};
    if (state_reg.pin_sync[1] == state_reg.pin_sync[2]) begin
      state_next.phys_level = state_reg.pin_sync[2];
    end

    // one-cycle DFT rejects all harmonics below the sampling alias
    if (measurement_mode_in == resov_pkg::MODE_PHASE) begin
      x = 18'(phase_a_in) + 18'(phase_b_in) + 18'(phase_c_in);
    end else begin
      x = 18'(residual_in);
    end
    p_re = x * dft_coef(state_reg.dft_idx);
    p_im = x * dft_coef(3'(state_reg.dft_idx - 3'h2));
    f_re = state_reg.acc_re + 32'(p_re);
    f_im = state_reg.acc_im + 32'(p_im);
    if (sample_strobe_in) begin
      state_next.dft_idx = state_reg.dft_idx + 3'h1;
      state_next.acc_re = f_re;
      state_next.acc_im = f_im;
      if (state_reg.dft_idx == 3'h7) begin
        mx = abs32(f_re) > abs32(f_im) ? abs32(f_re) : abs32(f_im);
        mn = abs32(f_re) > abs32(f_im) ? abs32(f_im) : abs32(f_re);
        mag = mx + (mn >> 2) + (mn >> 3);
        scaled = mag * ((measurement_mode_in == resov_pkg::MODE_PHASE) ?
                        phase_scale_in : residual_scale_in);
        // percent of nominal over root three, saturating
        state_next.level = (scaled[47:32] != '0) ? '1 : scaled[31:16];
        state_next.acc_re = '0;
        state_next.acc_im = '0;
      end
    end

    // millisecond enable
    state_next.ms_tick = 1'b0;
    if (state_reg.ms_cnt >= MS_CYCLES - 16'h1) begin
      state_next.ms_cnt = '0;
      state_next.ms_tick = 1'b1;
    end else begin
      state_next.ms_cnt = state_reg.ms_cnt + 16'h1;
    end

    // settings, all behind the password
    if (password_ok_in) begin
      if (cfg_write_in) begin
        state_next.pickup[cfg_group_in][cfg_stage_in] = cfg_pickup_in;
        state_next.delay_ms[cfg_group_in][cfg_stage_in] = cfg_delay_in;
      end
      if (group_write_in) begin
        state_next.manual_group = group_manual_in;
      end
      if (source_write_in && group_select_source_in <= 3'h4) begin
        state_next.source =
          resov_pkg::group_source_e'(group_select_source_in);
      end
    end

    unique case (state_reg.source)
      resov_pkg::SRC_NONE: sel_level = 1'b0;
      resov_pkg::SRC_PHYSICAL: sel_level = state_reg.phys_level;
      resov_pkg::SRC_SOFT_INPUT: sel_level = soft_input_n_in;
      resov_pkg::SRC_INDICATOR: sel_level = indicator_signal_n_in;
      resov_pkg::SRC_SOFT_OUTPUT: sel_level = soft_output_n_in;
      default: sel_level = 1'b0;
    endcase
    state_next.active_grp = sel_level ? resov_pkg::GROUP_BY_SIGNAL :
                            state_reg.manual_group;

    // shared force flag with its own timeout
    if (state_reg.force_flag) begin
      state_next.force_cnt = state_reg.force_cnt + 36'h1;
      if (state_reg.force_cnt >= FORCE_TIMEOUT_CYCLES - 36'h1) begin
        state_next.force_flag = 1'b0;
      end
    end
    if (password_ok_in && force_clear_in) begin
      state_next.force_flag = 1'b0;
    end
    if (password_ok_in && force_set_in) begin
      state_next.force_flag = 1'b1;
      state_next.force_cnt = '0;
    end
    if (!state_next.force_flag) begin
      state_next.ovr_en = '0;
    end else if (force_write_in && state_reg.force_flag) begin
      // only start and trip may be forced; idle releases it
      if (force_status_in == resov_pkg::ST_START ||
          force_status_in == resov_pkg::ST_TRIP) begin
        state_next.ovr_en[force_stage_in] = 1'b1;
        state_next.ovr_val[force_stage_in] = force_status_in;
      end else if (force_status_in == resov_pkg::ST_IDLE) begin
        state_next.ovr_en[force_stage_in] = 1'b0;
      end
    end

    for (int s = 0; s < 2; s++) begin
      // status: forced, else blocked, else live
      if (state_reg.ovr_en[s]) begin
        state_next.status[s] = state_reg.ovr_val[s];
      end else if (block_in[s]) begin
        state_next.status[s] = resov_pkg::ST_BLOCKED;
      end else if (st_trip[s]) begin
        state_next.status[s] = resov_pkg::ST_TRIP;
      end else if (st_start[s]) begin
        state_next.status[s] = resov_pkg::ST_START;
      end else begin
        state_next.status[s] = resov_pkg::ST_IDLE;
      end
      state_next.start[s] = state_next.status[s][1];
      state_next.trip[s] = state_next.status[s] == resov_pkg::ST_TRIP;

      // an event in the clearing cycle still counts
      state_next.prev_start[s] = st_start[s];
      state_next.prev_trip[s] = st_trip[s];
      if (start_count_clear_in[s]) begin
        state_next.start_cnt[s] = '0;
      end
      if (st_start[s] && !state_reg.prev_start[s]) begin
        state_next.start_cnt[s] = state_next.start_cnt[s] + 16'h1;
      end
      if (trip_count_clear_in[s]) begin
        state_next.trip_cnt[s] = '0;
      end
      if (st_trip[s] && !state_reg.prev_trip[s]) begin
        state_next.trip_cnt[s] = state_next.trip_cnt[s] + 16'h1;
      end

      // fault ring, both stages may write in one cycle
      if (st_rec_valid[s]) begin
        state_next.r_date[wp] = rtc_date_in;
        state_next.r_time[wp] = rtc_time_in;
        state_next.r_level[wp] = st_rec_peak[s];
        state_next.r_pct[wp] = st_rec_pct[s];
        state_next.r_group[wp] = state_reg.active_grp;
        state_next.r_stage[wp] = 1'(s);
        wp = wp + 3'h1;
        if (state_next.rec_count != 4'h8) begin
          state_next.rec_count = state_next.rec_count + 4'h1;
        end
      end
    end
    state_next.wr_ptr = wp;

    // index 0 is the newest record
    wp = 3'(state_reg.wr_ptr - 3'h1 - rec_index_in);
    state_next.o_date = state_reg.r_date[wp];
    state_next.o_time = state_reg.r_time[wp];
    state_next.o_level = state_reg.r_level[wp];
    state_next.o_pct = state_reg.r_pct[wp];
    state_next.o_group = state_reg.r_group[wp];
    state_next.o_stage = state_reg.r_stage[wp];
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= '0;
      state_reg.pickup <= {8{resov_pkg::PICKUP_RESET}};
      state_reg.delay_ms <= {8{resov_pkg::DELAY_RESET}};
      state_reg.manual_group <= resov_pkg::GROUP_RESET;
      state_reg.active_grp <= resov_pkg::GROUP_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // outputs
  assign start_out = state_reg.start;
  assign trip_out = state_reg.trip;
  assign status_out = state_reg.status;
  assign start_event_count_out = state_reg.start_cnt;
  assign trip_event_count_out = state_reg.trip_cnt;
  assign active_settings_group_out = state_reg.active_grp;
  assign force_flag_out = state_reg.force_flag;
  assign supervised_residual_level_out = state_reg.level;
  assign rec_count_out = state_reg.rec_count;
  assign rec_date_out = state_reg.o_date;
  assign rec_time_out = state_reg.o_time;
  assign rec_level_out = state_reg.o_level;
  assign elapsed_delay_percent_out = state_reg.o_pct;
  assign rec_group_out = state_reg.o_group;
  assign rec_stage_out = state_reg.o_stage;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_bad_write;
    cfg_write_in && !password_ok_in && !$past(cfg_write_in);
  endsequence

  a_auth_blocks_write: assert property (
    s_bad_write |=> $stable(state_reg.pickup) && $stable(state_reg.delay_ms))
    else $error("setting changed without password");
  a_force_timeout: assert property (
    state_reg.force_flag |-> state_reg.force_cnt < FORCE_TIMEOUT_CYCLES)
    else $error("force flag outlived its timeout");
  a_force_gates_ovr: assert property (
    !state_reg.force_flag |-> state_reg.ovr_en == 2'b00)
    else $error("status forced without force flag");
  a_blocked_shows: assert property (
    block_in[0] && !state_reg.ovr_en[0] |=> status_out[0] == 2'b01)
    else $error("blocked stage not reported");
  a_start_counts: assert property (
    $rose(st_start[0]) && !start_count_clear_in[0]
    |=> start_event_count_out[0] == $past(start_event_count_out[0]) + 16'h1)
    else $error("start counter missed an event");
  a_record_advances: assert property (
    st_rec_valid == 2'b01 |=> state_reg.wr_ptr == $past(state_reg.wr_ptr) + 3'h1)
    else $error("record pointer did not advance");
  a_trip_to_output: assert property (
    st_trip[1] && !block_in[1] && !state_reg.ovr_en[1] |=> trip_out[1])
    else $error("stage trip not shown on output");
endmodule

/* residual_source.sv */
`timescale 1ns/1ps
// ==========================================================
// residual transformer model: square wave, eight samples per cycle
module residual_source (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // control and samples
  input wire logic enable_in,
  output logic strobe_out,
  output logic signed [15:0] sample_out
);
  logic [4:0] step_reg;
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) step_reg <= 5'h00;
    else step_reg <= step_reg + 5'h01;
  end
  // strobes run from reset so sample index 0 matches the design's count
  assign strobe_out = (step_reg[1:0] == 2'h3);
  // square wave carries a strong third harmonic on purpose
  assign sample_out = !enable_in ? 16'sh0000 :
    (step_reg[4] ? -16'sh2000 : 16'sh2000);
endmodule

/* test_residual_overvoltage_stage.sv */
`timescale 1ns/1ps
// ==========================================================
// bench
module test_residual_overvoltage_stage;
  logic sys_clk_in, resetn_in, sample_strobe_in, measurement_mode_in;
  logic password_ok_in, cfg_write_in, cfg_stage_in, group_write_in, src_en;
  logic source_write_in, physical_input_n_in, soft_input_n_in;
  logic indicator_signal_n_in, soft_output_n_in, force_set_in;
  logic force_clear_in, force_write_in, force_stage_in, rec_stage_out;
  logic force_flag_out;
  logic [15:0] phase_a_in, phase_b_in, phase_c_in, residual_in;
  logic [15:0] phase_scale_in, residual_scale_in, cfg_pickup_in;
  logic [15:0] supervised_residual_level_out, rec_level_out;
  logic [19:0] cfg_delay_in;
  logic [1:0] cfg_group_in, group_manual_in, block_in, force_status_in;
  logic [1:0] start_count_clear_in, trip_count_clear_in, start_out, trip_out;
  logic [1:0] active_settings_group_out, rec_group_out;
  logic [2:0] group_select_source_in, rec_index_in;
  logic [3:0] rec_count_out;
  logic [31:0] rtc_date_in, rec_date_out;
  logic [33:0] rtc_time_in, rec_time_out;
  logic [6:0] elapsed_delay_percent_out;
  logic [1:0][1:0] status_out;
  logic [1:0][15:0] start_event_count_out, trip_event_count_out;
  int error_cnt, tests_run, cyc;
  // short ms tick and force timeout keep the run brief
  residual_overvoltage_stage #(.MS_CYCLES(16'h000A),
    .FORCE_TIMEOUT_CYCLES(36'h1F4)) residual_overvoltage_stage_inst (.*);
  residual_source residual_source_inst (.sys_clk_in, .resetn_in,
    .enable_in(src_en), .strobe_out(sample_strobe_in),
    .sample_out(residual_in));
  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  task automatic pulse_cfg(input logic [15:0] pk, input logic st);
    clk(1);
    cfg_pickup_in <= pk;
    cfg_stage_in <= st;
    cfg_delay_in <= 20'h00003;
    cfg_write_in <= 1'b1;
    clk(1);
    cfg_write_in <= 1'b0;
  endtask
  task automatic refuse_test;
    pulse_cfg(16'h0100, 1'b0);
    src_en <= 1'b1;
    clk(100);
    chk(16'(start_out), 16'h0000);
    src_en <= 1'b0;
    clk(100);
  endtask
  task automatic trip_test;
    int k;
    int n;
    password_ok_in <= 1'b1;
    pulse_cfg(16'h0100, 1'b0);
    pulse_cfg(16'hF000, 1'b1);
    src_en <= 1'b1;
    for (k = 0; k < 200 && start_out[0] !== 1'b1; k++) clk(1);
    chk(16'(start_out), 16'h0001);
    for (n = 0; n < 200 && trip_out[0] !== 1'b1; n++) clk(1);
    chk(16'(n >= 18 && n <= 45), 16'h0001);
    clk(3);
    chk(16'(status_out), 16'h0003);
    chk(start_event_count_out[0], 16'h0001);
    chk(trip_event_count_out[0], 16'h0001);
    chk(16'(rec_count_out), 16'h0001);
    chk(16'(elapsed_delay_percent_out), 16'h0064);
    chk(rec_date_out[15:0], 16'h2468);
    chk(rec_time_out[15:0], 16'h1A2B);
    clk(32);
    chk(supervised_residual_level_out, 16'h0B28);
    src_en <= 1'b0;
    clk(100);
    chk(16'(start_out), 16'h0000);
    start_count_clear_in <= 2'h1;
    clk(1);
    start_count_clear_in <= 2'h0;
    clk(3);
    chk(start_event_count_out[0], 16'h0000);
  endtask
  task automatic group_test;
    clk(1);
    {group_manual_in, group_select_source_in} <= {2'h3, 3'h2};
    {group_write_in, source_write_in, force_set_in} <= 3'h7;
    clk(1);
    {group_write_in, source_write_in, force_set_in} <= 3'h0;
    clk(3);
    chk(16'(active_settings_group_out), 16'h0003);
    chk(16'(force_flag_out), 16'h0001);
    soft_input_n_in <= 1'b1;
    // force high stage to trip while the low stage is blocked
    {force_write_in, force_stage_in, force_status_in, block_in} <= 6'h3D;
    clk(1);
    force_write_in <= 1'b0;
    clk(3);
    chk(16'(active_settings_group_out), 16'h0001);
    chk(16'(status_out), 16'h000D);
    chk(16'(trip_out), 16'h0002);
    block_in <= 2'h0;
    clk(510);
    chk(16'(force_flag_out), 16'h0000);
    chk(16'(trip_out), 16'h0000);
    // phase mode must ignore the live residual input
    {measurement_mode_in, src_en} <= 2'h1;
    clk(70);
    chk(supervised_residual_level_out, 16'h0000);
  endtask
  initial begin
    {resetn_in, password_ok_in, cfg_write_in, cfg_stage_in, group_write_in,
      source_write_in, physical_input_n_in, soft_input_n_in, src_en,
      indicator_signal_n_in, soft_output_n_in, force_set_in, force_clear_in,
      force_write_in, force_stage_in} = '0;
    {phase_a_in, phase_b_in, phase_c_in, phase_scale_in, cfg_pickup_in,
      cfg_delay_in, cfg_group_in, group_manual_in, block_in, rec_index_in,
      force_status_in, start_count_clear_in, trip_count_clear_in,
      group_select_source_in, rtc_date_in, rtc_time_in} = '0;
    // scale puts the test level between the low and the high pick-up
    {measurement_mode_in, residual_scale_in} = {1'b1, 16'h0010};
    {rtc_date_in, rtc_time_in} = {32'h13572468, 34'h000001A2B};
    {error_cnt, tests_run, cyc} = '0;
    clk(16);
    resetn_in <= 1'b1;
    clk(2);
    chk(16'(status_out), 16'h0000);
    refuse_test;
    trip_test;
    group_test;
    tally_and_finish;
  end
endmodule
